// ---- srw_pkg.sv ----
package srw_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned RP_US [4] = '{1_400, 28_000, 200_000, 1_600_000};
    localparam int unsigned WD_US [4] = '{6_300, 102_000, 1_600_000, 25_600_000};
    localparam int unsigned LONG_PRESS_US = 4_000_000;
    localparam int unsigned RESTART_US = 500_000;
    localparam int unsigned I2C_MAX_HZ = 400_000;
    // quarter of an scl period, rounded up so the bus never runs too fast
    localparam int unsigned QTR_CYC = (CLK_HZ + 4 * I2C_MAX_HZ - 1) / (4 * I2C_MAX_HZ);

    // ---------------------------------------------------------------
    // fuse defaults
    // ---------------------------------------------------------------
    localparam int unsigned RP_SEL_DEFAULT = 2;
    localparam int unsigned WD_SEL_DEFAULT = 2;
    localparam bit SWITCH_MODE_DEFAULT = 1'b0;

    // ---------------------------------------------------------------
    // serial port and registers
    // ---------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h4a;
    localparam logic [7:0] SUB_BUTTON_STAT = 8'h0e;
    localparam logic [7:0] SUB_FORCE_SHUT = 8'h10;
    localparam logic [7:0] SHUT_CODE = 8'ha9;
    localparam int unsigned STAT_LIVE_BIT = 0;
    localparam int unsigned STAT_EVENT_BIT = 1;
    localparam logic [3:0] BIT_LAST = 4'h8;
endpackage

// ---- srw_link_if.sv ----
interface srw_link_if;
    logic mstSclOe;
    logic mstSdaOe;
    logic slvSdaOe;
    logic wdiLevel;
    logic wdiOe;
    logic rstOe;
    logic sclLine;
    logic sdaLine;
    logic rstLine;

    // open-drain lines with pull-ups
    assign sclLine = ~mstSclOe;
    assign sdaLine = ~(mstSdaOe | slvSdaOe);
    assign rstLine = ~rstOe;

    modport device (
        input sclLine,
        input sdaLine,
        input wdiLevel,
        input wdiOe,
        output slvSdaOe,
        output rstOe
    );
    modport host (
        input sclLine,
        input sdaLine,
        input rstLine,
        output mstSclOe,
        output mstSdaOe,
        output wdiLevel,
        output wdiOe
    );
endinterface

// ---- srw_device.sv ----
// Summary of operation
// RQ1: reset on low rail or watchdog expiry
// RQ2: hold reset for selectable hold period
// RQ3: undervoltage asserts reset after delay
// RQ4: every toggle edge clears watchdog counter
// RQ5: expiry at selectable watchdog period
// RQ6: watchdog cleared and stopped during reset
// RQ7: undriven toggle input disables watchdog
// RQ8: processor toggles within every watchdog period
// RQ9: button mode fuse, processor reset default
// RQ10: short negative button glitches ignored
// RQ11: button low resets, then hold period
// RQ12: four second press shuts channels down
// RQ13: half second press in standby restarts
// RQ14: code write forces immediate shutdown
// RQ15: live flag and latched event flag
// RQ16: enable pins clear button shutdown state
// RQ17: writing one clears status bit
// RQ18: serial clock at most 400 kHz
// RQ19: general call ignored, own address only
// RQ20: address 0x4A, optional select pin
// RQ21: read transfer serves one master only
// RQ22: subaddress selects register for data
// RQ23: supervisor active while any enable high
// RQ24: watchdog held clear while inactive
module srw_device #(
    parameter int unsigned RP_SEL = srw_pkg::RP_SEL_DEFAULT,
    parameter int unsigned WD_SEL = srw_pkg::WD_SEL_DEFAULT,
    parameter bit SWITCH_MODE = srw_pkg::SWITCH_MODE_DEFAULT,
    parameter bit USE_ADDR_PIN = 1'b0,
    parameter int unsigned RD_CYC = 1,
    parameter int unsigned HOLD_CYC = srw_pkg::RP_US[RP_SEL] * srw_pkg::CYC_PER_US,
    parameter int unsigned WD_CYC = srw_pkg::WD_US[WD_SEL] * srw_pkg::CYC_PER_US,
    parameter int unsigned LONG_CYC = srw_pkg::LONG_PRESS_US * srw_pkg::CYC_PER_US,
    parameter int unsigned RESTART_CYC = srw_pkg::RESTART_US * srw_pkg::CYC_PER_US
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    srw_link_if.device link,
    input wire logic railSenseIn,
    input wire logic buttonReset_n,
    input wire logic [3:0] channelEnablePins,
    input wire logic addressSelectPin,
    output logic [3:0] channelRun,
    output logic channelPowerControlClear,
    output logic buttonLiveFlag,
    output logic buttonEventFlag,
    output logic buttonIrq_n
);
    import srw_pkg::*;

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    localparam int unsigned NIN = 10;
    logic [NIN-1:0] rawIn, s1_r, s2_r, s3_r, filt_r, filtPrev_r;
    assign rawIn = {link.sclLine, link.sdaLine, link.wdiLevel, link.wdiOe, railSenseIn,
                    buttonReset_n, channelEnablePins};
    wire logic [NIN-1:0] filtNxt = (s3_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
            filt_r <= '1;
            filtPrev_r <= '1;
        end
        else
        begin
            s1_r <= rawIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filtNxt;
            filtPrev_r <= filt_r;
        end
    end

    wire logic sclF = filt_r[9];
    wire logic sdaF = filt_r[8];
    wire logic wdiF = filt_r[7];
    wire logic wdiDriven = filt_r[6];
    wire logic railOk = filt_r[5];
    // two agreeing samples span 100 ns, so shorter low glitches never count
    wire logic buttonLow = ~filt_r[4]; // [RQ10]
    wire logic [3:0] enF = filt_r[3:0];
    wire logic supActive = |enF; // [RQ23]
    wire logic buttonFall = buttonLow & filtPrev_r[4];
    wire logic enRise = |(enF & ~filtPrev_r[3:0]);

    // ---------------------------------------------------------------
    // reset generation and watchdog
    // ---------------------------------------------------------------
    logic [31:0] rdCnt_r, holdCnt_r, wdCnt_r;
    logic rstOe_r;
    wire logic railLow = (rdCnt_r == RD_CYC); // [RQ3]
    wire logic wdExpire = (wdCnt_r == WD_CYC - 1); // [RQ5]
    wire logic procButton = ~SWITCH_MODE & buttonLow; // [RQ9] [RQ11]
    wire logic resetCause = railLow | procButton | wdExpire | ~supActive; // [RQ1]
    wire logic resetOn = resetCause | (holdCnt_r != 32'h0);
    // watchdog only runs while supervising, out of reset and driven
    wire logic wdClear = ~supActive | resetOn | ~wdiDriven | (wdiF ^ filtPrev_r[7]);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rdCnt_r <= 32'h0;
            // leaving reset counts as a rail recovery, so the hold runs first
            holdCnt_r <= HOLD_CYC;
            wdCnt_r <= 32'h0;
            rstOe_r <= 1'b1;
        end
        else
        begin
            rdCnt_r <= railOk ? 32'h0 : (railLow ? rdCnt_r : rdCnt_r + 32'h1); // [RQ3]
            holdCnt_r <= resetCause ? HOLD_CYC : (resetOn ? holdCnt_r - 32'h1 : 32'h0); // [RQ2]
            wdCnt_r <= wdClear ? 32'h0 : wdCnt_r + 32'h1; // [RQ4] [RQ6] [RQ7] [RQ24]
            rstOe_r <= resetOn; // [RQ1]
        end
    end
    assign link.rstOe = rstOe_r;

    // ---------------------------------------------------------------
    // power on/off switch
    // ---------------------------------------------------------------
    typedef enum logic {PWR_ON, PWR_STANDBY} srw_pwr_t;
    srw_pwr_t pwr_r;
    logic [31:0] pressCnt_r;
    logic armed_r, pcClear_r, event_r;
    logic [3:0] run_r;
    logic forceWr;
    wire logic switchPress = SWITCH_MODE & buttonLow & armed_r;
    wire logic longPress = (pwr_r == PWR_ON) & (pressCnt_r >= LONG_CYC); // [RQ12]
    wire logic restartPress = (pwr_r == PWR_STANDBY) & (pressCnt_r >= RESTART_CYC); // [RQ13]
    wire logic shutNow = longPress | forceWr; // [RQ14]
    wire logic enClear = (pwr_r == PWR_STANDBY) & (~supActive | enRise); // [RQ16]
    logic evClr;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pwr_r <= PWR_ON;
            pressCnt_r <= 32'h0;
            armed_r <= 1'b1;
            pcClear_r <= 1'b0;
            run_r <= 4'h0;
            event_r <= 1'b0;
        end
        else
        begin
            case (pwr_r)
                PWR_ON: pwr_r <= shutNow ? PWR_STANDBY : PWR_ON;
                PWR_STANDBY: pwr_r <= (restartPress | enClear) ? PWR_ON : PWR_STANDBY;
                default: pwr_r <= PWR_ON;
            endcase
            // a held button must be let go before it can start a restart press
            armed_r <= (shutNow | restartPress) ? 1'b0 : (armed_r | ~buttonLow);
            pressCnt_r <= (switchPress & ~shutNow & ~restartPress) ? pressCnt_r + 32'h1 : 32'h0;
            pcClear_r <= shutNow & (pwr_r == PWR_ON); // [RQ12]
            run_r <= (pwr_r == PWR_ON && !shutNow) ? enF : 4'h0; // [RQ13] [RQ14]
            event_r <= buttonFall | (event_r & ~evClr); // [RQ15] [RQ17]
        end
    end
    assign channelRun = run_r;
    assign channelPowerControlClear = pcClear_r;
    assign buttonLiveFlag = buttonLow; // [RQ15]
    assign buttonEventFlag = event_r;
    assign buttonIrq_n = ~event_r;

    // ---------------------------------------------------------------
    // serial slave port
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_SUB, S_WDATA, S_RDATA, S_ACK, S_RACK} srw_ser_t;
    srw_ser_t ser_r, after_r;
    logic [7:0] shift_r, sub_r;
    logic [3:0] bits_r;
    logic sdaOe_r;
    wire logic sclRise = sclF & ~filtPrev_r[9]; // [RQ18]
    wire logic sclFall = ~sclF & filtPrev_r[9];
    wire logic inRead = (ser_r == S_RDATA) | (ser_r == S_RACK);
    wire logic startSeen = sclF & filtPrev_r[9] & ~sdaF & filtPrev_r[8] & ~inRead; // [RQ21]
    wire logic stopSeen = sclF & filtPrev_r[9] & sdaF & ~filtPrev_r[8];
    wire logic [6:0] myAddr = USE_ADDR_PIN ? {SLAVE_ADDR[6:1], addressSelectPin} : SLAVE_ADDR;
    wire logic byteDone = sclFall & (bits_r == BIT_LAST);
    wire logic addrHit = (shift_r[7:1] == myAddr); // [RQ19] [RQ20]
    wire logic wrStrobe = byteDone & (ser_r == S_WDATA);
    wire logic [7:0] rdData = (sub_r == SUB_BUTTON_STAT) ?
        8'(({7'h0, event_r} << STAT_EVENT_BIT) | ({7'h0, buttonLow} << STAT_LIVE_BIT)) : 8'h0;
    assign forceWr = wrStrobe & (sub_r == SUB_FORCE_SHUT) & (shift_r == SHUT_CODE); // [RQ14]
    assign evClr = wrStrobe & (sub_r == SUB_BUTTON_STAT) & shift_r[STAT_EVENT_BIT]; // [RQ17]

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ser_r <= S_IDLE;
            after_r <= S_IDLE;
            shift_r <= 8'h0;
            sub_r <= 8'h0;
            bits_r <= 4'h0;
            sdaOe_r <= 1'b0;
        end
        else if (stopSeen)
        begin
            ser_r <= S_IDLE;
            sdaOe_r <= 1'b0;
        end
        else if (startSeen)
        begin
            ser_r <= S_ADDR;
            bits_r <= 4'h0;
            sdaOe_r <= 1'b0;
        end
        else
        begin
            case (ser_r)
                S_ADDR, S_SUB, S_WDATA:
                begin
                    if (sclRise)
                    begin
                        shift_r <= {shift_r[6:0], sdaF};
                        bits_r <= bits_r + 4'h1;
                    end
                    else if (byteDone)
                    begin
                        bits_r <= 4'h0;
                        if (ser_r == S_ADDR && !addrHit)
                            ser_r <= S_IDLE;
                        else
                        begin
                            ser_r <= S_ACK;
                            sdaOe_r <= 1'b1;
                            if (ser_r == S_ADDR)
                                after_r <= shift_r[0] ? S_RDATA : S_SUB;
                            else
                                after_r <= S_WDATA;
                            if (ser_r == S_SUB)
                                sub_r <= shift_r; // [RQ22]
                            else if (ser_r == S_WDATA)
                                sub_r <= sub_r + 8'h1;
                        end
                    end
                end
                S_ACK:
                    if (sclFall)
                    begin
                        ser_r <= after_r;
                        sdaOe_r <= (after_r == S_RDATA) ? ~rdData[7] : 1'b0; // [RQ22]
                        shift_r <= {rdData[6:0], 1'b0};
                        // only a read has its first bit already on the line
                        bits_r <= (after_r == S_RDATA) ? 4'h1 : 4'h0;
                    end
                S_RDATA:
                    if (sclFall)
                    begin
                        if (bits_r == BIT_LAST)
                        begin
                            ser_r <= S_RACK;
                            sdaOe_r <= 1'b0;
                            sub_r <= sub_r + 8'h1;
                        end
                        else
                        begin
                            sdaOe_r <= ~shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                            bits_r <= bits_r + 4'h1;
                        end
                    end
                S_RACK:
                    // master ack asks for another byte, nack ends the read
                    if (sclRise)
                        ser_r <= sdaF ? S_IDLE : S_ACK;
                default: ser_r <= S_IDLE;
            endcase
        end
    end
    assign link.slvSdaOe = sdaOe_r;
endmodule

// ---- srw_host.sv ----
module srw_host (
    input wire logic sys_clk,
    input wire logic rst_n,
    srw_link_if.host link,
    input wire logic cmdStart,
    input wire logic cmdRead,
    input wire logic [7:0] cmdSub,
    input wire logic [7:0] cmdData,
    input wire logic [6:0] cmdAddr,
    output logic cmdBusy,
    output logic cmdDone,
    output logic cmdNack,
    output logic [7:0] rdData,
    input wire logic wdEnable,
    input wire logic wdToggle,
    output logic processorInReset
);
    import srw_pkg::*;

    // ---------------------------------------------------------------
    // processor side: watchdog toggling and reset input
    // ---------------------------------------------------------------
    logic wdi_r, r1_r, r2_r, r3_r, rstF_r;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wdi_r <= 1'b0;
            r1_r <= 1'b0;
            r2_r <= 1'b0;
            r3_r <= 1'b0;
            rstF_r <= 1'b0;
        end
        else
        begin
            wdi_r <= wdi_r ^ wdToggle; // [RQ8]
            r1_r <= link.rstLine;
            r2_r <= r1_r;
            r3_r <= r2_r;
            rstF_r <= (r2_r == r3_r) ? r3_r : rstF_r;
        end
    end
    assign link.wdiLevel = wdi_r;
    // releasing the driver turns monitoring off in the device
    assign link.wdiOe = wdEnable; // [RQ7]
    assign processorInReset = ~rstF_r;

    // ---------------------------------------------------------------
    // serial master
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} srw_mst_t;
    srw_mst_t st_r;
    logic [7:0] div_r, sub_r, data_r, rx_r;
    logic [6:0] addr_r;
    logic [1:0] qtr_r, byteIdx_r;
    logic [3:0] bit_r;
    logic read_r, sclOe_r, sdaOe_r, done_r, nack_r, sdaS1_r, sdaS2_r;
    wire logic qTick = (div_r == 8'h0); // [RQ18]
    wire logic rxByte = (byteIdx_r == 2'd3);
    wire logic [7:0] txByte = (byteIdx_r == 2'd0) ? {addr_r, 1'b0} :
                              (byteIdx_r == 2'd1) ? sub_r :
                              (byteIdx_r == 2'd2 && read_r) ? {addr_r, 1'b1} : data_r;
    wire logic ackBit = (bit_r == BIT_LAST);
    wire logic txBit = ackBit | rxByte | txByte[3'(7 - bit_r)];
    wire logic lastByte = read_r ? rxByte : (byteIdx_r == 2'd2);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_r <= M_IDLE;
            div_r <= 8'h0;
            qtr_r <= 2'd0;
            bit_r <= 4'h0;
            byteIdx_r <= 2'd0;
            {addr_r, sub_r, data_r, rx_r, rdData} <= '0;
            {read_r, sclOe_r, sdaOe_r, done_r, nack_r, sdaS1_r, sdaS2_r} <= '0;
        end
        else
        begin
            div_r <= qTick ? 8'(QTR_CYC - 1) : div_r - 8'h1;
            sdaS1_r <= link.sdaLine;
            sdaS2_r <= sdaS1_r;
            done_r <= 1'b0;
            case (st_r)
                M_IDLE:
                    if (cmdStart)
                    begin
                        st_r <= M_START;
                        {addr_r, sub_r, data_r, read_r} <= {cmdAddr, cmdSub, cmdData, cmdRead};
                        byteIdx_r <= 2'd0;
                        qtr_r <= 2'd0;
                        nack_r <= 1'b0;
                    end
                M_START:
                    if (qTick)
                    begin
                        qtr_r <= qtr_r + 2'd1;
                        case (qtr_r)
                            2'd0: sdaOe_r <= 1'b0;
                            2'd1: sclOe_r <= 1'b0;
                            2'd2: sdaOe_r <= 1'b1;
                            default:
                            begin
                                sclOe_r <= 1'b1;
                                st_r <= M_BIT;
                                bit_r <= 4'h0;
                            end
                        endcase
                    end
                M_BIT:
                    if (qTick)
                    begin
                        qtr_r <= qtr_r + 2'd1;
                        case (qtr_r)
                            2'd0: sdaOe_r <= ~txBit;
                            2'd1: sclOe_r <= 1'b0;
                            2'd2:
                                if (ackBit && !rxByte)
                                    nack_r <= sdaS2_r;
                                else if (rxByte && !ackBit)
                                    rx_r <= {rx_r[6:0], sdaS2_r};
                            default:
                            begin
                                sclOe_r <= 1'b1;
                                bit_r <= bit_r + 4'h1;
                                if (ackBit)
                                begin
                                    bit_r <= 4'h0;
                                    byteIdx_r <= byteIdx_r + 2'd1;
                                    // subaddress then repeated start for a read
                                    if (nack_r || lastByte)
                                        st_r <= M_STOP; // [RQ22]
                                    else if (read_r && byteIdx_r == 2'd1)
                                        st_r <= M_START;
                                end
                            end
                        endcase
                    end
                M_STOP:
                    if (qTick)
                    begin
                        qtr_r <= qtr_r + 2'd1;
                        case (qtr_r)
                            2'd0: sdaOe_r <= 1'b1;
                            2'd1: sclOe_r <= 1'b0;
                            2'd2:
                            begin
                                sdaOe_r <= 1'b0;
                                st_r <= M_IDLE;
                                done_r <= 1'b1;
                                rdData <= rx_r;
                            end
                            default: st_r <= M_IDLE;
                        endcase
                    end
                default: st_r <= M_IDLE;
            endcase
        end
    end
    assign link.mstSclOe = sclOe_r;
    assign link.mstSdaOe = sdaOe_r;
    assign cmdBusy = (st_r != M_IDLE);
    assign cmdDone = done_r;
    assign cmdNack = nack_r;
endmodule

// ---- srw_monitor.sv ----
module srw_monitor #(
    parameter int HOLD_CYC = 50,
    parameter int WD_CYC = 200
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclLine,
    input wire logic slvSdaOe,
    input wire logic wdiLevel,
    input wire logic wdiOe,
    input wire logic rstOe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD_MIN = HOLD_CYC - 1;
    // raw toggle pin is seen before its filter, so allow that latency
    localparam int WD_LATE = WD_CYC + 12;
    int hiCnt_r;
    int wdCnt_r;
    int perCnt_r;
    logic wdiLevel_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------
    // helper counters
    // ----------------
    always_ff @(posedge sys_clk) wdiLevel_r <= wdiLevel;
    always_ff @(posedge sys_clk) hiCnt_r <= (!rst_n || !rstOe) ? 0 : hiCnt_r + 1;
    always_ff @(posedge sys_clk)
        wdCnt_r <= (!rst_n || rstOe || !wdiOe || wdiLevel != wdiLevel_r) ? 0 : wdCnt_r + 1;
    always_ff @(posedge sys_clk) perCnt_r <= !rst_n ? 255 : ($rose(sclLine) ? 0 : perCnt_r + 1);
    AST_RST_AT_RELEASE: assert property ($rose(rst_n) |-> rstOe)
        else $error("reset output low at release");
    AST_SDA_FREE_AT_RELEASE: assert property ($rose(rst_n) |-> !slvSdaOe)
        else $error("slave drives sda at release");
    AST_HOLD_MIN: assert property ($fell(rstOe) |-> hiCnt_r >= HOLD_MIN)
        else $error("reset released before hold period");
    AST_PULSE_MIN: assert property ($rose(rstOe) |=> rstOe [*8])
        else $error("reset pulse too short");
    AST_WD_EXPIRY: assert property (wdCnt_r <= WD_LATE)
        else $error("watchdog period passed without reset");
    AST_QUIET_AFTER_RELEASE: assert property ($fell(rstOe) |=> !rstOe [*3])
        else $error("reset reasserted at release");
    AST_SCL_RATE: assert property ($rose(sclLine) |-> perCnt_r >= 24)
        else $error("serial clock too fast");
    AST_SDA_ON_SCL_LOW: assert property ($changed(slvSdaOe) |-> !sclLine)
        else $error("slave sda moved while scl high");
endmodule

// ---- srw_bench.sv ----
module srw_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import srw_pkg::*;
    localparam int HOLD = 50;
    localparam int WD = 200;
    localparam int LONG = 300;
    localparam int RESTART = 100;
    logic sys_clk = 1'b0;
    logic rst_n, railSenseIn, buttonReset_n, cmdStart, cmdRead, wdEnable, wdToggle;
    logic [3:0] channelEnablePins, channelRun;
    logic [7:0] cmdSub, cmdData, rdData;
    logic [6:0] cmdAddr;
    logic pcClear, buttonLiveFlag, buttonEventFlag, buttonIrq_n, cmdBusy, cmdDone, cmdNack;
    logic processorInReset;
    logic clrSeen_r = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    srw_link_if link ();
    srw_device #(.SWITCH_MODE(1'b1), .HOLD_CYC(HOLD), .WD_CYC(WD), .LONG_CYC(LONG),
        .RESTART_CYC(RESTART)) u_srw_device (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .railSenseIn(railSenseIn), .buttonReset_n(buttonReset_n), .addressSelectPin(1'b0),
        .channelEnablePins(channelEnablePins), .channelRun(channelRun),
        .channelPowerControlClear(pcClear), .buttonLiveFlag(buttonLiveFlag),
        .buttonEventFlag(buttonEventFlag), .buttonIrq_n(buttonIrq_n));
    srw_host u_srw_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .cmdStart(cmdStart),
        .cmdRead(cmdRead), .cmdSub(cmdSub), .cmdData(cmdData), .cmdAddr(cmdAddr),
        .cmdBusy(cmdBusy), .cmdDone(cmdDone), .cmdNack(cmdNack), .rdData(rdData),
        .wdEnable(wdEnable), .wdToggle(wdToggle), .processorInReset(processorInReset));
    srw_monitor #(.HOLD_CYC(HOLD), .WD_CYC(WD)) u_srw_monitor (.sys_clk(sys_clk),
        .rst_n(rst_n), .sclLine(link.sclLine), .slvSdaOe(link.slvSdaOe),
        .wdiLevel(link.wdiLevel), .wdiOe(link.wdiOe), .rstOe(link.rstOe));
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (pcClear === 1'b1)
            clrSeen_r <= 1'b1;
    // ----------
    // scenarios
    // ----------
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic toggle;
        wdToggle = 1'b1;
        cyc(1);
        wdToggle = 1'b0;
    endtask
    task automatic i2c(input logic rd, input logic [6:0] a, input logic [7:0] s,
        input logic [7:0] d);
        int k;
        cmdRead = rd;
        cmdAddr = a;
        cmdSub = s;
        cmdData = d;
        cmdStart = 1'b1;
        cyc(1);
        cmdStart = 1'b0;
        check(cmdBusy, 1'b1);
        // bounded so a lost stop cannot hang the run
        for (k = 0; k < 3000 && cmdDone !== 1'b1; k++)
            cyc(1);
        check(k < 3000, 1'b1);
        check(cmdBusy, 1'b0);
    endtask
    task automatic wait_rst(input logic lvl, input int lim, output int n);
        for (n = 0; n < lim && processorInReset !== lvl; n++)
            cyc(1);
    endtask
    task automatic check_hold;
        int n;
        wait_rst(1'b0, HOLD + 20, n);
        check(n >= HOLD && n < HOLD + 20, 1'b1);
    endtask
    task automatic t_watchdog;
        int n;
        wdEnable = 1'b1;
        repeat (5)
        begin
            cyc(WD - 40);
            toggle;
        end
        check(processorInReset, 1'b0);
        wait_rst(1'b1, WD + 40, n);
        check(n >= WD && n < WD + 20, 1'b1);
        check_hold;
        wdEnable = 1'b0;
        cyc(2 * WD);
        check(processorInReset, 1'b0);
    endtask
    task automatic t_rail;
        int n;
        wdEnable = 1'b1;
        railSenseIn = 1'b0;
        wait_rst(1'b1, 20, n);
        check(n < 20, 1'b1);
        cyc(2 * WD);
        check(processorInReset, 1'b1);
        railSenseIn = 1'b1;
        check_hold;
        cyc(WD - 40);
        check(processorInReset, 1'b0);
        wdEnable = 1'b0;
    endtask
    task automatic t_long_press;
        buttonReset_n = 1'b0;
        cyc(1);
        buttonReset_n = 1'b1;
        cyc(10);
        check(buttonEventFlag, 1'b0);
        buttonReset_n = 1'b0;
        cyc(LONG + 20);
        check(channelRun, 8'h00);
        check(clrSeen_r, 1'b1);
        buttonReset_n = 1'b1;
        cyc(10);
        buttonReset_n = 1'b0;
        cyc(RESTART + 20);
        buttonReset_n = 1'b1;
        check(channelRun, channelEnablePins);
    endtask
    task automatic t_serial;
        buttonReset_n = 1'b0;
        cyc(10);
        check(buttonLiveFlag, 1'b1);
        buttonReset_n = 1'b1;
        cyc(10);
        check(buttonIrq_n, 1'b0);
        i2c(1'b1, SLAVE_ADDR, SUB_BUTTON_STAT, 8'h00);
        check(rdData, 8'h01 << STAT_EVENT_BIT);
        i2c(1'b0, SLAVE_ADDR, SUB_BUTTON_STAT, 8'h01 << STAT_EVENT_BIT);
        i2c(1'b1, SLAVE_ADDR, SUB_BUTTON_STAT, 8'h00);
        check(rdData, 8'h00);
        i2c(1'b0, 7'h00, SUB_FORCE_SHUT, SHUT_CODE);
        check(cmdNack, 1'b1);
        i2c(1'b0, SLAVE_ADDR ^ 7'h01, SUB_FORCE_SHUT, SHUT_CODE);
        check({cmdNack, channelRun}, 8'h1f);
        i2c(1'b0, SLAVE_ADDR, SUB_FORCE_SHUT, SHUT_CODE);
        check(channelRun, 8'h00);
        channelEnablePins = 4'h0;
        cyc(20);
        check(processorInReset, 1'b1);
        channelEnablePins = 4'h5;
        cyc(10);
        check(channelRun, 8'h05);
    endtask
    task automatic summarize;
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        mismatches++;
        summarize;
    end
    initial
    begin
        {rst_n, railSenseIn, buttonReset_n, cmdStart, cmdRead, wdEnable, wdToggle} = 7'h30;
        {channelEnablePins, cmdSub, cmdData, cmdAddr} = {4'hf, 23'h0};
        cyc(6);
        rst_n = 1'b1;
        cyc(HOLD - 10);
        check(processorInReset, 1'b1);
        cyc(30);
        check(processorInReset, 1'b0);
        t_watchdog;
        t_rail;
        t_long_press;
        t_serial;
        summarize;
    end
endmodule
